// ===== hw/fzo_pkg.sv
// fzo_pkg: constants for the fp zero-divide / overflow exception unit
// assumes fp values travel in 64-bit double layout, singles widened to it
package fzo_pkg;

  // operation kinds from the execution datapath
  typedef enum logic [1:0] {
    FZO_OP_ARITH = 2'h0,
    FZO_OP_DIV   = 2'h1,
    FZO_OP_RECIP = 2'h2,
    FZO_OP_RSQRT = 2'h3
  } fzo_op_t;

  // rounding select codes
  localparam logic [1:0] FZO_RM_NEAR = 2'h0;
  localparam logic [1:0] FZO_RM_ZERO = 2'h1;
  localparam logic [1:0] FZO_RM_PINF = 2'h2;
  localparam logic [1:0] FZO_RM_MINF = 2'h3;

  // exponent limits and trap adjustments (unbiased, signed)
  localparam logic signed [13:0] FZO_DBL_EMAX = 14'sh03FF;
  localparam logic signed [13:0] FZO_SGL_EMAX = 14'sh007F;
  localparam logic signed [13:0] FZO_DBL_ADJ  = 14'sh0600;
  localparam logic signed [13:0] FZO_SGL_ADJ  = 14'sh00C0;
  localparam logic signed [13:0] FZO_DBL_BIAS = 14'sh03FF;

  // magnitudes in double layout
  localparam logic [62:0] FZO_INF_MAG     = 63'h7FF0_0000_0000_0000;
  localparam logic [62:0] FZO_DBL_MAX_MAG = 63'h7FEF_FFFF_FFFF_FFFF;
  localparam logic [62:0] FZO_SGL_MAX_MAG = 63'h47EF_FFFF_E000_0000;

  // result class codes
  localparam logic [4:0] FZO_CLS_PINF  = 5'h05;
  localparam logic [4:0] FZO_CLS_NINF  = 5'h09;
  localparam logic [4:0] FZO_CLS_PNORM = 5'h04;
  localparam logic [4:0] FZO_CLS_NNORM = 5'h08;

  // register offsets
  localparam logic [7:0] FZO_ADDR_STCTL = 8'h00;
  localparam logic [7:0] FZO_ADDR_TMD   = 8'h04;
  localparam logic [7:0] FZO_ADDR_ISTAT = 8'h08;
  localparam logic [7:0] FZO_ADDR_IMASK = 8'h0C;

  // status/control word field positions
  localparam int FZO_B_RM   = 0;
  localparam int FZO_B_ZT   = 2;
  localparam int FZO_B_OE   = 3;
  localparam int FZO_B_ZS   = 4;
  localparam int FZO_B_OS   = 5;
  localparam int FZO_B_XS   = 6;
  localparam int FZO_B_RU   = 7;
  localparam int FZO_B_RI   = 8;
  localparam int FZO_B_SUM  = 9;
  localparam int FZO_B_RCLS = 10;

  // interrupt status bits
  localparam int FZO_I_ZDIV = 0;
  localparam int FZO_I_OVF  = 1;
  localparam int FZO_I_PEXC = 2;

  // reset values
  localparam logic [14:0] FZO_STCTL_RST = 15'h0000;
  localparam logic [1:0]  FZO_TMD_RST   = 2'h0;
  localparam logic [2:0]  FZO_IRQ_RST   = 3'h0;

endpackage : fzo_pkg

// ===== hw/fzo_ovf_if.sv
// fzo_ovf_if: carries the overflow operand to the result picker and back
// assumes both ends sit on the same clock; purely combinational bundle
`timescale 1ns/1ps
interface fzo_ovf_if;
  logic               sign;
  logic signed [13:0] exp;
  logic [51:0]        frac;
  logic               single;
  logic [1:0]         rmode;
  logic [63:0]        trap_bits;
  logic [63:0]        dflt_bits;
  logic               dflt_inf;

  modport req  (output sign, exp, frac, single, rmode,
                input  trap_bits, dflt_bits, dflt_inf);
  modport calc (input  sign, exp, frac, single, rmode,
                output trap_bits, dflt_bits, dflt_inf);
endinterface : fzo_ovf_if

// ===== hw/fzo_ovf_pick.sv
// fzo_ovf_pick: builds trapped and default results for an overflow
// assumes exponent is the unbounded, already rounded one
`timescale 1ns/1ps
module fzo_ovf_pick (
  fzo_ovf_if.calc ovf
);
  import fzo_pkg::*;

  logic signed [13:0] adj_exp;
  logic signed [13:0] biased;
  logic               toward_sign;
  logic [62:0]        max_mag;

  ////////////////////////////////////////////////////////////////////////
  // trapped: scale exponent back into range, keep rounded fraction
  assign adj_exp = ovf.exp - (ovf.single ? FZO_SGL_ADJ : FZO_DBL_ADJ); // see [RULE12] [RULE13]
  assign biased  = adj_exp + FZO_DBL_BIAS;
  assign ovf.trap_bits = {ovf.sign, biased[10:0], ovf.frac}; // see [RULE14]

  ////////////////////////////////////////////////////////////////////////
  // untrapped default: infinity for nearest, or when directed rounding heads toward the sign
  assign toward_sign = (ovf.rmode == FZO_RM_NEAR)
                     | ((ovf.rmode == FZO_RM_PINF) & ~ovf.sign)
                     | ((ovf.rmode == FZO_RM_MINF) & ovf.sign); // see [RULE16] [RULE17] [RULE19]
  assign max_mag   = ovf.single ? FZO_SGL_MAX_MAG : FZO_DBL_MAX_MAG;
  assign ovf.dflt_inf  = toward_sign;
  assign ovf.dflt_bits = {ovf.sign, toward_sign ? FZO_INF_MAG : max_mag}; // see [RULE16] [RULE17]

endmodule : fzo_ovf_pick

// ===== hw/fzo_exc_unit.sv
// fzo_exc_unit: zero-divide and overflow exception logic with status word
// assumes one op per valid pulse from the datapath, fields stable that cycle
// What this block does
// [RULE1] divide: zero divisor, finite nonzero dividend
// [RULE2] reciprocal estimates of zero also zero-divide
// [RULE3] estimate of zero gives infinity, operand sign
// [RULE4] zero-divide always sets its sticky flag
// [RULE5] zero-divide clears rounded-up and inexact-round
// [RULE6] trapped zero-divide: no write, summary set
// [RULE7] untrapped zero-divide: signed infinity written, class infinity
// [RULE8] summary set and trap mode nonzero: exception
// [RULE9] overflow judged on unbounded, rounded result
// [RULE10] overflow when magnitude exceeds largest finite
// [RULE11] overflow always sets its sticky flag
// [RULE12] trapped double overflow: exponent minus 1536
// [RULE13] trapped single overflow: exponent minus 192
// [RULE14] trapped overflow: store adjusted, summary, rounding flags
// [RULE15] untrapped overflow: default, inexact flags set
// [RULE16] default by rounding mode and sign
// [RULE17] directed rounding: infinity only toward sign
// [RULE18] storing depends on enables, not trap mode
// [RULE19] rounding codes: nearest, zero, plus, minus
`timescale 1ns/1ps
module fzo_exc_unit (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // operation from the datapath
  input  wire logic               op_valid,
  input  wire fzo_pkg::fzo_op_t   op_kind,
  input  wire logic               op_single,
  input  wire logic               a_sign,
  input  wire logic               a_zero,
  input  wire logic               a_finite,
  input  wire logic               b_sign,
  input  wire logic               b_zero,
  input  wire logic               res_sign,
  input  wire logic signed [13:0] res_exp,
  input  wire logic [51:0]        res_frac,
  input  wire logic               res_inexact,
  input  wire logic               res_round_up,
  input  wire logic [63:0]        res_bits,
  input  wire logic [4:0]         res_class,
  // result towards the target register
  output logic                    target_wr,
  output logic [63:0]             target_fp_register,
  // exception and interrupt
  output logic                    prog_exc,
  output logic                    irq
);
  import fzo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_i_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////
  // status/control word and trap mode state
  logic [1:0] rounding_select;
  logic       divide_by_nil_trap_enable;
  logic       overflow_trap_enable;
  logic       divide_by_nil_sticky_flag;
  logic       overflow_sticky_flag;
  logic       inexact_sticky_flag;
  logic       rounded_up_flag;
  logic       inexact_round_flag;
  logic       enabled_summary_flag;
  logic [4:0] result_class_field;
  logic       fp_trap_mode_bit_a;
  logic       fp_trap_mode_bit_b;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;

  ////////////////////////////////////////////////////////////////////////
  // condition detection
  wire is_div = op_valid & (op_kind == FZO_OP_DIV);
  wire is_est = op_valid & ((op_kind == FZO_OP_RECIP) | (op_kind == FZO_OP_RSQRT));
  wire is_ari = op_valid & (op_kind == FZO_OP_ARITH);

  wire zdiv_div = is_div & b_zero & a_finite & ~a_zero; // see [RULE1]
  wire zdiv_est = is_est & b_zero;                      // see [RULE2]
  wire zdiv     = zdiv_div | zdiv_est;

  // estimates take the zero's own sign, a divide the xor of both
  wire zdiv_sign = zdiv_est ? b_sign : (a_sign ^ b_sign); // see [RULE3] [RULE7]

  // divides and estimates of finite values cannot overflow here
  wire signed [13:0] emax = op_single ? FZO_SGL_EMAX : FZO_DBL_EMAX;
  wire ovf = is_ari & (res_exp > emax); // see [RULE9] [RULE10]

  // only the enables pick the stored value; trap mode never does
  wire zdiv_trap = zdiv & divide_by_nil_trap_enable;   // see [RULE18]
  wire zdiv_free = zdiv & ~divide_by_nil_trap_enable;
  wire ovf_trap  = ovf & overflow_trap_enable;         // see [RULE18]
  wire ovf_free  = ovf & ~overflow_trap_enable;
  wire plain     = op_valid & ~zdiv & ~ovf;

  ////////////////////////////////////////////////////////////////////////
  // overflow result picker
  fzo_ovf_if ovf_bus ();
  assign ovf_bus.sign   = res_sign;
  assign ovf_bus.exp    = res_exp;
  assign ovf_bus.frac   = res_frac;
  assign ovf_bus.single = op_single;
  assign ovf_bus.rmode  = rounding_select;

  fzo_ovf_pick u_pick (
    .ovf (ovf_bus.calc)
  );

  ////////////////////////////////////////////////////////////////////////
  // result selection
  wire [63:0] zdiv_bits = {zdiv_sign, FZO_INF_MAG};
  wire        wr_next   = zdiv_free | ovf | plain; // see [RULE6]
  wire [63:0] data_next = zdiv_free ? zdiv_bits            // see [RULE7]
                        : ovf_trap  ? ovf_bus.trap_bits    // see [RULE14]
                        : ovf_free  ? ovf_bus.dflt_bits    // see [RULE15]
                        : res_bits;

  ////////////////////////////////////////////////////////////////////////
  // flag updates from hardware
  wire sum_set = zdiv_trap | ovf_trap; // see [RULE6] [RULE14]
  wire zs_set  = zdiv;                 // see [RULE4]
  wire os_set  = ovf;                  // see [RULE11]
  wire xs_set  = ovf_free                              // see [RULE15]
               | ((ovf_trap | plain) & res_inexact);   // see [RULE14]

  // rounding flags: zero-divide clears, overflow reflects or forces
  wire rnd_upd = zdiv | ovf | plain;
  wire ru_hw   = (ovf_trap | plain) & res_round_up;     // see [RULE5] [RULE14]
  wire ri_hw   = ovf_free | ((ovf_trap | plain) & res_inexact); // see [RULE5] [RULE15]

  // class: trapped zero-divide keeps the old class
  wire       cls_upd = zdiv_free | ovf | plain;
  wire [4:0] cls_inf = zdiv_sign ? FZO_CLS_NINF : FZO_CLS_PINF;
  wire [4:0] cls_ovi = res_sign ? FZO_CLS_NINF : FZO_CLS_PINF;
  wire [4:0] cls_nrm = res_sign ? FZO_CLS_NNORM : FZO_CLS_PNORM;
  wire [4:0] cls_hw  = zdiv_free ? cls_inf                       // see [RULE7]
                     : ovf_trap  ? cls_nrm                       // see [RULE14]
                     : ovf_free  ? (ovf_bus.dflt_inf ? cls_ovi : cls_nrm) // see [RULE15]
                     : res_class;

  // trap mode only gates the exception itself
  wire exc_next = sum_set & (fp_trap_mode_bit_a | fp_trap_mode_bit_b); // see [RULE8]

  ////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_stctl = reg_wr & (reg_addr == FZO_ADDR_STCTL);
  wire wr_tmd   = reg_wr & (reg_addr == FZO_ADDR_TMD);
  wire wr_istat = reg_wr & (reg_addr == FZO_ADDR_ISTAT);
  wire wr_imask = reg_wr & (reg_addr == FZO_ADDR_IMASK);

  wire [14:0] stctl_word = {result_class_field,
                            enabled_summary_flag,
                            inexact_round_flag,
                            rounded_up_flag,
                            inexact_sticky_flag,
                            overflow_sticky_flag,
                            divide_by_nil_sticky_flag,
                            overflow_trap_enable,
                            divide_by_nil_trap_enable,
                            rounding_select};

  // sticky bits: a hardware set beats a software clear in the same cycle
  wire sw_zs  = wr_stctl ? reg_wdata[FZO_B_ZS]  : divide_by_nil_sticky_flag;
  wire sw_os  = wr_stctl ? reg_wdata[FZO_B_OS]  : overflow_sticky_flag;
  wire sw_xs  = wr_stctl ? reg_wdata[FZO_B_XS]  : inexact_sticky_flag;
  wire sw_sum = wr_stctl ? reg_wdata[FZO_B_SUM] : enabled_summary_flag;
  wire sw_ru  = wr_stctl ? reg_wdata[FZO_B_RU]  : rounded_up_flag;
  wire sw_ri  = wr_stctl ? reg_wdata[FZO_B_RI]  : inexact_round_flag;
  wire [4:0] sw_cls = wr_stctl ? reg_wdata[FZO_B_RCLS +: 5] : result_class_field;

  wire zs_next  = sw_zs | zs_set;
  wire os_next  = sw_os | os_set;
  wire xs_next  = sw_xs | xs_set;
  wire sum_next = sw_sum | sum_set; // summary untouched when untrapped
  wire ru_next  = rnd_upd ? ru_hw : sw_ru;
  wire ri_next  = rnd_upd ? ri_hw : sw_ri;
  wire [4:0] cls_next = cls_upd ? cls_hw : sw_cls;

  // interrupt status: write one to clear, events win
  wire [2:0] irq_ev   = {exc_next, ovf, zdiv};
  wire [2:0] irq_keep = wr_istat ? (irq_stat_reg & ~reg_wdata[2:0]) : irq_stat_reg;
  wire [2:0] irq_stat_next = irq_keep | irq_ev;

  ////////////////////////////////////////////////////////////////////////
  // read mux
  wire [31:0] rd_mux = (reg_addr == FZO_ADDR_STCTL) ? {17'h00000, stctl_word}
                     : (reg_addr == FZO_ADDR_TMD)   ? {30'h00000000,
                                                       fp_trap_mode_bit_b,
                                                       fp_trap_mode_bit_a}
                     : (reg_addr == FZO_ADDR_ISTAT) ? {29'h00000000, irq_stat_reg}
                     : (reg_addr == FZO_ADDR_IMASK) ? {29'h00000000, irq_mask_reg}
                     : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // control fields written only by software
  always_ff @(posedge ref_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rounding_select           <= FZO_STCTL_RST[1:0];
      divide_by_nil_trap_enable <= FZO_STCTL_RST[FZO_B_ZT];
      overflow_trap_enable      <= FZO_STCTL_RST[FZO_B_OE];
      fp_trap_mode_bit_a        <= FZO_TMD_RST[0];
      fp_trap_mode_bit_b        <= FZO_TMD_RST[1];
      irq_mask_reg              <= FZO_IRQ_RST;
    end else begin
      if (wr_stctl) begin
        rounding_select           <= reg_wdata[FZO_B_RM +: 2]; // see [RULE19]
        divide_by_nil_trap_enable <= reg_wdata[FZO_B_ZT];
        overflow_trap_enable      <= reg_wdata[FZO_B_OE];
      end
      if (wr_tmd) begin
        fp_trap_mode_bit_a <= reg_wdata[0];
        fp_trap_mode_bit_b <= reg_wdata[1];
      end
      if (wr_imask) begin
        irq_mask_reg <= reg_wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge ref_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      divide_by_nil_sticky_flag <= FZO_STCTL_RST[FZO_B_ZS];
      overflow_sticky_flag      <= FZO_STCTL_RST[FZO_B_OS];
      inexact_sticky_flag       <= FZO_STCTL_RST[FZO_B_XS];
      rounded_up_flag           <= FZO_STCTL_RST[FZO_B_RU];
      inexact_round_flag        <= FZO_STCTL_RST[FZO_B_RI];
      enabled_summary_flag      <= FZO_STCTL_RST[FZO_B_SUM];
      result_class_field        <= FZO_STCTL_RST[FZO_B_RCLS +: 5];
      irq_stat_reg              <= FZO_IRQ_RST;
    end else begin
      divide_by_nil_sticky_flag <= zs_next;  // see [RULE4]
      overflow_sticky_flag      <= os_next;  // see [RULE11]
      inexact_sticky_flag       <= xs_next;
      rounded_up_flag           <= ru_next;  // see [RULE5]
      inexact_round_flag        <= ri_next;  // see [RULE5]
      enabled_summary_flag      <= sum_next; // see [RULE6]
      result_class_field        <= cls_next;
      irq_stat_reg              <= irq_stat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; one cycle behind the op
  always_ff @(posedge ref_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      target_wr          <= 1'b0;
      target_fp_register <= 64'h0000_0000_0000_0000;
      prog_exc           <= 1'b0;
      reg_rdata          <= 32'h0000_0000;
    end else begin
      target_wr <= wr_next; // see [RULE6]
      if (wr_next) begin
        target_fp_register <= data_next;
      end
      prog_exc  <= exc_next; // see [RULE8]
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // level interrupt, no pulse stretching needed
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule : fzo_exc_unit

// ===== test/fzo_exc_unit_assertions.sv
// fzo_exc_unit_assertions: port checks for the fp exception unit
// assumes bind to fzo_exc_unit; enables mirrored from register writes
`timescale 1ns/1ps
module fzo_exc_unit_assertions (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               op_valid,
  input wire fzo_pkg::fzo_op_t   op_kind,
  input wire logic               op_single,
  input wire logic               a_sign,
  input wire logic               a_zero,
  input wire logic               a_finite,
  input wire logic               b_sign,
  input wire logic               b_zero,
  input wire logic               res_sign,
  input wire logic signed [13:0] res_exp,
  input wire logic               target_wr,
  input wire logic [63:0]        target_fp_register,
  input wire logic               prog_exc
);
  import fzo_pkg::*;
  ////////////////////////////////////////
  // software owns enables and mode, so a write mirror is exact
  logic [3:0] ctl_reg;
  logic [1:0] mode_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg  <= 4'h0;
      mode_reg <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == FZO_ADDR_STCTL) ctl_reg <= reg_wdata[3:0];
      if (reg_addr == FZO_ADDR_TMD) mode_reg <= reg_wdata[1:0];
    end
  end
  wire zd_c = op_valid && op_kind == FZO_OP_DIV && b_zero && a_finite && !a_zero;
  wire es_c = op_valid && (op_kind == FZO_OP_RECIP || op_kind == FZO_OP_RSQRT) && b_zero;
  wire ov_c = op_valid && op_kind == FZO_OP_ARITH && !op_single && res_exp > FZO_DBL_EMAX;
  ////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_inf(s);
    target_wr && target_fp_register == {s, FZO_INF_MAG};
  endsequence
  zd_inf_wr_a: assert property (zd_c && !ctl_reg[2] |=> wr_inf($past(a_sign ^ b_sign)))
    else $error("untrapped zero divide wrote wrong value");
  est_inf_a: assert property (es_c && !ctl_reg[2] |=> wr_inf($past(b_sign)))
    else $error("estimate of zero wrote wrong value");
  zd_trap_a: assert property ((zd_c || es_c) && ctl_reg[2] |=> !target_wr)
    else $error("trapped zero divide wrote target");
  trap_exc_a: assert property ((zd_c || es_c) && ctl_reg[2] && mode_reg != 2'h0 |=> prog_exc)
    else $error("trapped zero divide raised no exception");
  mode_off_a: assert property (op_valid && mode_reg == 2'h0 |=> !prog_exc)
    else $error("exception with trap mode off");
  zd_quiet_a: assert property ((zd_c || es_c) && !ctl_reg[2] |=> !prog_exc)
    else $error("untrapped zero divide raised exception");
  ovf_adj_a: assert property (ov_c && ctl_reg[3] |=> target_wr && target_fp_register[62:52] ==
    11'($past(res_exp) - FZO_DBL_ADJ + FZO_DBL_BIAS)) else $error("trapped overflow exponent wrong");
  ovf_zero_a: assert property (ov_c && !ctl_reg[3] && ctl_reg[1:0] == FZO_RM_ZERO |=>
    target_fp_register == {$past(res_sign), FZO_DBL_MAX_MAG}) else $error("overflow default wrong");
endmodule : fzo_exc_unit_assertions

// ===== test/fzo_dp_model.sv
// fzo_dp_model: execution datapath stand-in feeding the op port
// assumes the bench calls issue(); fields drift once a pulse is over
`timescale 1ns/1ps
module fzo_dp_model #(
  parameter logic [51:0] FRAC = 52'h0
) (
  input wire logic         ref_clk,
  output logic             op_valid,
  output fzo_pkg::fzo_op_t op_kind,
  output logic             op_single,
  output logic             a_sign,
  output logic             a_zero,
  output logic             a_finite,
  output logic             b_sign,
  output logic             b_zero,
  output logic             res_sign,
  output logic signed [13:0] res_exp,
  output logic [51:0]      res_frac,
  output logic             res_inexact,
  output logic             res_round_up,
  output logic [63:0]      res_bits,
  output logic [4:0]       res_class
);
  import fzo_pkg::*;
  initial begin
    {op_valid, op_single, a_sign, a_zero, a_finite, b_sign, b_zero} = 7'h00;
    {res_sign, res_exp, res_inexact, res_round_up} = 17'h00000;
    op_kind = FZO_OP_ARITH;
    res_frac = FRAC;
    res_bits = 64'h0;
    res_class = 5'h00;
  end
  // one op per call; a is sign/zero/finite, b is sign/zero, r is inexact/up
  task automatic issue(input fzo_op_t k, input logic sg, input logic [2:0] a,
                       input logic [1:0] b, input logic s, input logic signed [13:0] e,
                       input logic [1:0] r);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    {op_single, a_sign, a_zero, a_finite, b_sign, b_zero} <= {sg, a, b};
    {res_sign, res_exp, res_inexact, res_round_up} <= {s, e, r};
    res_bits <= {s, 11'(e + FZO_DBL_BIAS), FRAC};
    res_class <= s ? FZO_CLS_NNORM : FZO_CLS_PNORM;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    // stale fields must not look valid
    {b_zero, res_exp} <= {~b_zero, ~res_exp};
  endtask : issue
endmodule : fzo_dp_model

// ===== test/fzo_exc_unit_tb.sv
// fzo_exc_unit_tb: directed scenarios for the fp exception unit
// assumes the datapath model drives the op port; registers driven here
`timescale 1ns/1ps
module fzo_exc_unit_tb;
  import fzo_pkg::*;
  localparam logic [51:0] F = 52'hA_BCDE_E000_0000;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic op_valid, op_single, a_sign, a_zero, a_finite, b_sign, b_zero, res_sign;
  logic res_inexact, res_round_up, target_wr, prog_exc, irq;
  fzo_op_t op_kind;
  logic signed [13:0] res_exp;
  logic [51:0] res_frac;
  logic [63:0] res_bits, target_fp_register;
  logic [4:0] res_class;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #20 ref_clk = ~ref_clk;
  fzo_exc_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_kind(op_kind), .op_single(op_single), .a_sign(a_sign),
    .a_zero(a_zero), .a_finite(a_finite), .b_sign(b_sign), .b_zero(b_zero),
    .res_sign(res_sign), .res_exp(res_exp), .res_frac(res_frac), .res_inexact(res_inexact),
    .res_round_up(res_round_up), .res_bits(res_bits), .res_class(res_class),
    .target_wr(target_wr), .target_fp_register(target_fp_register), .prog_exc(prog_exc),
    .irq(irq));
  fzo_dp_model #(.FRAC(F)) dp_u (.ref_clk(ref_clk), .op_valid(op_valid), .op_kind(op_kind),
    .op_single(op_single), .a_sign(a_sign), .a_zero(a_zero), .a_finite(a_finite),
    .b_sign(b_sign), .b_zero(b_zero), .res_sign(res_sign), .res_exp(res_exp),
    .res_frac(res_frac), .res_inexact(res_inexact), .res_round_up(res_round_up),
    .res_bits(res_bits), .res_class(res_class));
  ////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // whole run needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp("reg_rdata", 64'(e), 64'(reg_rdata));
  endtask : rd_chk
  task automatic irq_chk(input logic e);
    @(negedge ref_clk);
    cmp("irq", 64'(e), 64'(irq));
  endtask : irq_chk
  task automatic op(input fzo_op_t k, input logic sg, input logic [2:0] a, input logic [1:0] b,
                    input logic s, input logic signed [13:0] e, input logic [1:0] r,
                    input logic ew, input logic [63:0] ev, input logic ex);
    dp_u.issue(k, sg, a, b, s, e, r);
    @(negedge ref_clk);
    cmp("target_wr", 64'(ew), 64'(target_wr));
    if (ew) cmp("target_fp_register", ev, target_fp_register);
    cmp("prog_exc", 64'(ex), 64'(prog_exc));
  endtask : op
  ////////////////////////////////////////
  task automatic t_zdiv;
    for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0);
    wr(8'h04, 32'h3);
    op(FZO_OP_ARITH, 1'b0, 3'b001, 2'b00, 1'b0, 14'sh0, 2'h3, 1'b1, {12'h3FF, F}, 1'b0);
    rd_chk(8'h00, 32'h11C0);
    op(FZO_OP_DIV, 1'b0, 3'b101, 2'b01, 1'b0, 14'sh0, 2'h3, 1'b1, {1'b1, FZO_INF_MAG}, 1'b0);
    rd_chk(8'h00, 32'h2450);
    rd_chk(8'h08, 32'h1);
    irq_chk(1'b0);
    wr(8'h0C, 32'h1);
    irq_chk(1'b1);
    wr(8'h08, 32'h1);
    irq_chk(1'b0);
    wr(8'h00, 32'h0);
    op(FZO_OP_DIV, 1'b0, 3'b011, 2'b01, 1'b0, 14'sh0, 2'h0, 1'b1, {12'h3FF, F}, 1'b0);
    op(FZO_OP_DIV, 1'b0, 3'b000, 2'b01, 1'b0, 14'sh0, 2'h0, 1'b1, {12'h3FF, F}, 1'b0);
    rd_chk(8'h00, 32'h1000);
  endtask : t_zdiv
  task automatic t_est_trap;
    for (int k = 2; k < 4; k++)
      for (int s = 0; s < 2; s++)
        op(fzo_op_t'(k), 1'b0, 3'b001, {s[0], 1'b1}, 1'b0, 14'sh0, 2'h0, 1'b1, {s[0], FZO_INF_MAG}, 1'b0);
    rd_chk(8'h00, 32'h2410);
    wr(8'h00, 32'h4);
    op(FZO_OP_DIV, 1'b0, 3'b001, 2'b11, 1'b0, 14'sh0, 2'h0, 1'b0, 64'h0, 1'b1);
    rd_chk(8'h00, 32'h0214);
    rd_chk(8'h08, 32'h5);
    wr(8'h04, 32'h0);
    op(FZO_OP_RECIP, 1'b0, 3'b001, 2'b01, 1'b0, 14'sh0, 2'h0, 1'b0, 64'h0, 1'b0);
  endtask : t_est_trap
  task automatic t_ovf;
    logic inf;
    logic [4:0] cl;
    logic [63:0] ev;
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h8);
    op(FZO_OP_ARITH, 1'b0, 3'b001, 2'b00, 1'b0, 14'sd1023, 2'h0, 1'b1, {12'h7FE, F}, 1'b0);
    op(FZO_OP_ARITH, 1'b0, 3'b001, 2'b00, 1'b1, 14'sd1100, 2'h2, 1'b1, {1'b1, 11'd587, F}, 1'b1);
    rd_chk(8'h00, 32'h2368);
    op(FZO_OP_ARITH, 1'b1, 3'b001, 2'b00, 1'b0, 14'sd127, 2'h0, 1'b1, {12'h47E, F}, 1'b0);
    op(FZO_OP_ARITH, 1'b1, 3'b001, 2'b00, 1'b0, 14'sd200, 2'h0, 1'b1, {1'b0, 11'd1031, F}, 1'b1);
    wr(8'h04, 32'h3);
    for (int r = 0; r < 4; r++)
      for (int s = 0; s < 2; s++) begin
        inf = (r == 0) || (r == 2 && s == 0) || (r == 3 && s == 1);
        cl = inf ? (s ? FZO_CLS_NINF : FZO_CLS_PINF) : (s ? FZO_CLS_NNORM : FZO_CLS_PNORM);
        ev = {s[0], inf ? FZO_INF_MAG : FZO_DBL_MAX_MAG};
        wr(8'h00, 32'(r));
        op(FZO_OP_ARITH, 1'b0, 3'b001, 2'b00, s[0], 14'sd1100, 2'h0, 1'b1, ev, 1'b0);
        rd_chk(8'h00, 32'(r) | 32'h160 | {17'h0, cl, 10'h0});
      end
    wr(8'h00, 32'h1);
    op(FZO_OP_ARITH, 1'b1, 3'b001, 2'b00, 1'b0, 14'sd200, 2'h0, 1'b1, {1'b0, FZO_SGL_MAX_MAG}, 1'b0);
  endtask : t_ovf
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_zdiv();
    t_est_trap();
    t_ovf();
    finish_test();
  end
endmodule : fzo_exc_unit_tb
bind fzo_exc_unit fzo_exc_unit_assertions chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .op_valid(op_valid),
  .op_kind(op_kind), .op_single(op_single), .a_sign(a_sign), .a_zero(a_zero),
  .a_finite(a_finite), .b_sign(b_sign), .b_zero(b_zero), .res_sign(res_sign),
  .res_exp(res_exp), .target_wr(target_wr), .target_fp_register(target_fp_register),
  .prog_exc(prog_exc));
